/* File: include/ptc_pkg.sv */
// Package for the pattern timing control block: register map, fields, resets, types
package ptc_pkg;

  // ****************************************************************
  // Register offsets (word address on the plain register port)
  // ****************************************************************
  localparam logic [7:0] ADDR_UPDATE    = 8'h1D;
  localparam logic [7:0] ADDR_STATUS    = 8'h1E;
  localparam logic [7:0] ADDR_RPT_MODE  = 8'h1F;
  localparam logic [7:0] ADDR_TRIG_DLY  = 8'h20;
  localparam logic [7:0] ADDR_DIG_OFS   = 8'h25;
  localparam logic [7:0] ADDR_WAV_SRC   = 8'h27;
  localparam logic [7:0] ADDR_TBASE     = 8'h28;
  localparam logic [7:0] ADDR_PERIOD    = 8'h29;
  localparam logic [7:0] ADDR_RPT_CNT   = 8'h2B;
  localparam logic [7:0] ADDR_MRK_RISE  = 8'h2C;
  localparam logic [7:0] ADDR_MRK_CFG   = 8'h2D;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] RST_RPT_MODE = 16'h0000;
  localparam logic [15:0] RST_TRIG_DLY = 16'h000E;
  localparam logic [15:0] RST_DIG_OFS  = 16'h0000;
  localparam logic [15:0] RST_WAV_SRC  = 16'h0101;
  localparam logic [15:0] RST_TBASE    = 16'h0111;
  localparam logic [15:0] RST_PERIOD   = 16'h8000;
  localparam logic [15:0] RST_RPT_CNT  = 16'h0101;
  localparam logic [15:0] RST_MRK_RISE = 16'h0003;
  localparam logic [15:0] RST_MRK_CFG  = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_RUN        = 0;
  localparam int BIT_PLAYING    = 1;
  localparam int BIT_UPDATE     = 0;
  localparam int BIT_RPT_MODE   = 0;
  localparam int BIT_CH_SUM     = 2;
  localparam int LSB_GEN_SEL    = 4;
  localparam int LSB_WAVE_SEL   = 0;
  localparam int LSB_HOLD       = 8;
  localparam int LSB_PER_BASE   = 4;
  localparam int LSB_LEAD_BASE  = 0;
  localparam int BIT_MRK_LEVEL  = 5;
  localparam int BIT_MRK_MODE   = 4;
  localparam int LSB_MRK_FALL   = 0;

  typedef enum logic [1:0] {
    PTC_IDLE  = 2'b00,
    PTC_DELAY = 2'b01,
    PTC_PLAY  = 2'b10
  } ptc_state_e;

  // Active configuration, loaded on the update strobe
  typedef struct packed {
    logic        rpt_mode;
    logic [15:0] trig_dly;
    logic [11:0] dig_ofs;
    logic [1:0]  gen_sel;
    logic        ch_sum;
    logic [1:0]  wave_sel;
    logic [3:0]  hold;
    logic [3:0]  per_base;
    logic [3:0]  lead_base;
    logic [15:0] period;
    logic [7:0]  rpt_cnt;
    logic [15:0] mrk_rise;
    logic        mrk_level;
    logic        mrk_mode;
    logic [3:0]  mrk_fall;
  } ptc_cfg_s;

  // Sample word handed to the DAC path
  typedef struct packed {
    logic [1:0]  src;
    logic [1:0]  gen;
    logic        gated;
    logic [11:0] ofs;
  } ptc_samp_s;

endpackage : ptc_pkg

/* File: verilog/ptc_core.sv */
// Pattern timing control: registers, trigger sequencer, marker and sample strobe
//
// Notes on behaviour
// [RL1] Repeat bit clear runs pattern forever; set plays it repeat-count field plus one times.
// [RL2] Pattern starts trigger delay field plus one clocks after trigger falls.
// [RL3] Generator select: 0 constant, 1 sawtooth, 2 pseudorandom, 3 DDS.
// [RL4] Source select reset 1: RAM, prestored, gated prestored, RAM-modulated.
// [RL5] Channel-sum bit zero means normal DAC path operation.
// [RL6] Each sample is held hold field plus one sample strobes.
// [RL7] Period unit lasts period time base plus one clocks.
// [RL8] Start delay unit lasts lead-in time base plus one clocks.
// [RL9] Repeat count field, reset 1, encodes number of plays minus one.
// [RL10] Timed marker rises rise-delay clocks after trigger falls.
// [RL11] Timed marker falls fall-delay clocks after pattern end.
// [RL12] Marker mode 1 is timed, 0 is manual.
// [RL13] Manual level bit only matters in manual marker mode.
// [RL14] Host sets marker enable at address zero to put marker on pin.
// [RL15] Run bit enables generation; clearing it stops after trigger. The code stops the pattern at the end of the current period.
// [RL16] Update bit copies written settings to active set, then self-clears.
// [RL17] Period counter counts period times base, then restarts or stops.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
module ptc_core
  import ptc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // Trigger pin, active low
  input  wire logic        trigger_n_i,
  // Marker enable from address zero, kept outside this block
  input  wire logic        marker_en_i,
  // Sample stream towards the DAC path
  output logic             samp_valid_o,
  input  wire logic        samp_ready_i,
  output ptc_samp_s        samp_o,
  // Marker pin and playing status
  output logic             marker_o,
  output logic             marker_oe_o,
  output logic             playing_o
);

  // ****************************************************************
  // Register file: shadow (written) and active (after update)
  // ****************************************************************
  logic [15:0] sh_rpt_mode, sh_trig_dly, sh_dig_ofs, sh_wav_src, sh_tbase;
  logic [15:0] sh_period, sh_rpt_cnt, sh_mrk_rise, sh_mrk_cfg;
  logic        run;
  ptc_cfg_s    cfg;
  logic        upd_pulse;

  wire wr_upd   = reg_wr_i && (reg_addr_i == ADDR_UPDATE);
  wire wr_stat  = reg_wr_i && (reg_addr_i == ADDR_STATUS);
  wire do_upd   = wr_upd && reg_wdata_i[BIT_UPDATE];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_rpt_mode <= RST_RPT_MODE;
      sh_trig_dly <= RST_TRIG_DLY;
      sh_dig_ofs  <= RST_DIG_OFS;
      sh_wav_src  <= RST_WAV_SRC;
      sh_tbase    <= RST_TBASE;
      sh_period   <= RST_PERIOD;
      sh_rpt_cnt  <= RST_RPT_CNT;
      sh_mrk_rise <= RST_MRK_RISE;
      sh_mrk_cfg  <= RST_MRK_CFG;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_RPT_MODE) sh_rpt_mode <= reg_wdata_i;
      else if (reg_addr_i == ADDR_TRIG_DLY) sh_trig_dly <= reg_wdata_i;
      else if (reg_addr_i == ADDR_DIG_OFS) sh_dig_ofs <= reg_wdata_i;
      else if (reg_addr_i == ADDR_WAV_SRC) sh_wav_src <= reg_wdata_i;
      else if (reg_addr_i == ADDR_TBASE) sh_tbase <= reg_wdata_i;
      else if (reg_addr_i == ADDR_PERIOD) sh_period <= reg_wdata_i;
      else if (reg_addr_i == ADDR_RPT_CNT) sh_rpt_cnt <= reg_wdata_i;
      else if (reg_addr_i == ADDR_MRK_RISE) sh_mrk_rise <= reg_wdata_i;
      else if (reg_addr_i == ADDR_MRK_CFG) sh_mrk_cfg <= reg_wdata_i;
    end
  end

  // Update is a strobe: it reads back as zero, so it clears itself
  ptc_cfg_s next_cfg;
  assign next_cfg = '{
    rpt_mode:  sh_rpt_mode[BIT_RPT_MODE],
    trig_dly:  sh_trig_dly,
    dig_ofs:   sh_dig_ofs[15:4],
    gen_sel:   sh_wav_src[LSB_GEN_SEL +: 2],
    ch_sum:    sh_wav_src[BIT_CH_SUM],
    wave_sel:  sh_wav_src[LSB_WAVE_SEL +: 2],
    hold:      sh_tbase[LSB_HOLD +: 4],
    per_base:  sh_tbase[LSB_PER_BASE +: 4],
    lead_base: sh_tbase[LSB_LEAD_BASE +: 4],
    period:    sh_period,
    rpt_cnt:   sh_rpt_cnt[7:0],
    mrk_rise:  sh_mrk_rise,
    mrk_level: sh_mrk_cfg[BIT_MRK_LEVEL],
    mrk_mode:  sh_mrk_cfg[BIT_MRK_MODE],
    mrk_fall:  sh_mrk_cfg[LSB_MRK_FALL +: 4]
  };

  // Reset image of the active set, so outputs are defined before the first load
  localparam ptc_cfg_s RST_CFG = '{
    rpt_mode:  RST_RPT_MODE[BIT_RPT_MODE],
    trig_dly:  RST_TRIG_DLY,
    dig_ofs:   RST_DIG_OFS[15:4],
    gen_sel:   RST_WAV_SRC[LSB_GEN_SEL +: 2],
    ch_sum:    RST_WAV_SRC[BIT_CH_SUM],
    wave_sel:  RST_WAV_SRC[LSB_WAVE_SEL +: 2],
    hold:      RST_TBASE[LSB_HOLD +: 4],
    per_base:  RST_TBASE[LSB_PER_BASE +: 4],
    lead_base: RST_TBASE[LSB_LEAD_BASE +: 4],
    period:    RST_PERIOD,
    rpt_cnt:   RST_RPT_CNT[7:0],
    mrk_rise:  RST_MRK_RISE,
    mrk_level: RST_MRK_CFG[BIT_MRK_LEVEL],
    mrk_mode:  RST_MRK_CFG[BIT_MRK_MODE],
    mrk_fall:  RST_MRK_CFG[LSB_MRK_FALL +: 4]
  };

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg       <= RST_CFG;
      upd_pulse <= 1'b1;
      run       <= 1'b0;
    end else begin
      upd_pulse <= do_upd;
      if (upd_pulse) cfg <= next_cfg;         // [RL16]
      if (wr_stat) run <= reg_wdata_i[BIT_RUN];
    end
  end

  // ****************************************************************
  // Read-back, one cycle after the read strobe
  // ****************************************************************
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (reg_addr_i == ADDR_STATUS) rd_mux = {14'h0000, playing_o, run};
    else if (reg_addr_i == ADDR_RPT_MODE) rd_mux = sh_rpt_mode;
    else if (reg_addr_i == ADDR_TRIG_DLY) rd_mux = sh_trig_dly;
    else if (reg_addr_i == ADDR_DIG_OFS) rd_mux = sh_dig_ofs;
    else if (reg_addr_i == ADDR_WAV_SRC) rd_mux = sh_wav_src;
    else if (reg_addr_i == ADDR_TBASE) rd_mux = sh_tbase;
    else if (reg_addr_i == ADDR_PERIOD) rd_mux = sh_period;
    else if (reg_addr_i == ADDR_RPT_CNT) rd_mux = sh_rpt_cnt;
    else if (reg_addr_i == ADDR_MRK_RISE) rd_mux = sh_mrk_rise;
    else if (reg_addr_i == ADDR_MRK_CFG) rd_mux = sh_mrk_cfg;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) reg_rdata_o <= 16'h0000;
    else if (reg_rd_i) reg_rdata_o <= rd_mux;
    else reg_rdata_o <= 16'h0000;
  end

  // ****************************************************************
  // Trigger synchroniser and falling-edge detect
  // ****************************************************************
  logic trig_s1, trig_s2, trig_s3;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_s3 <= 1'b1;
    end else begin
      trig_s1 <= trigger_n_i;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end
  wire trig_fall = trig_s3 && !trig_s2;

  // ****************************************************************
  // Pattern sequencer
  // ****************************************************************
  ptc_state_e  state, next_state;
  logic [15:0] dly_cnt;
  logic [3:0]  base_cnt;
  logic [15:0] unit_cnt;
  logic [7:0]  plays;
  logic        hold_stall;

  wire in_play    = (state == PTC_PLAY);
  wire base_tick  = (base_cnt == cfg.per_base);                  // [RL7]
  wire period_end = in_play && base_tick && !hold_stall &&
                    (unit_cnt == cfg.period - 16'h0001);         // [RL17]
  wire last_play  = cfg.rpt_mode && (plays == cfg.rpt_cnt);      // [RL1] [RL9]
  wire pat_end    = period_end && (last_play || !run);           // [RL15]
  wire dly_done   = (dly_cnt == cfg.trig_dly);                   // [RL2]

  always_comb begin
    next_state = state;
    case (state)
      PTC_IDLE:  if (trig_fall && run) next_state = PTC_DELAY;   // [RL15]
      PTC_DELAY: if (dly_done) next_state = PTC_PLAY;
      PTC_PLAY:  if (pat_end) next_state = PTC_IDLE;
      default:   next_state = PTC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state    <= PTC_IDLE;
      dly_cnt  <= 16'h0000;
      base_cnt <= 4'h0;
      unit_cnt <= 16'h0000;
      plays    <= 8'h00;
    end else begin
      state <= next_state;
      if (state == PTC_DELAY) dly_cnt <= dly_cnt + 16'h0001;
      else dly_cnt <= 16'h0000;
      // A stalled tick must not restart the unit, or the period would gain clocks
      if (!in_play || (base_tick && !hold_stall)) base_cnt <= 4'h0;
      else if (!hold_stall) base_cnt <= base_cnt + 4'h1;
      if (!in_play || period_end) unit_cnt <= 16'h0000;
      else if (base_tick && !hold_stall) unit_cnt <= unit_cnt + 16'h0001;
      if (!in_play) plays <= 8'h00;
      else if (period_end) plays <= plays + 8'h01;
    end
  end
  assign playing_o = in_play;

  // ****************************************************************
  // Sample strobe: hold count, lead-in gating, two-entry buffer
  // ****************************************************************
  logic [3:0]  hold_cnt;
  logic [3:0]  lead_cnt;
  logic [15:0] lead_units;
  wire         hold_done = (hold_cnt == cfg.hold);               // [RL6]
  wire         lead_tick = (lead_cnt == cfg.lead_base);          // [RL8]

  // Buffer: a full buffer stalls the period counters so no word is lost
  ptc_samp_s   buf_q [2];
  logic [1:0]  buf_cnt;
  logic        buf_rd;
  wire         buf_full  = (buf_cnt == 2'd2);
  wire         samp_push = in_play && hold_done && !buf_full;
  assign       hold_stall = in_play && hold_done && buf_full;
  assign       buf_rd     = samp_valid_o && samp_ready_i;
  assign       samp_valid_o = (buf_cnt != 2'd0);
  assign       samp_o       = buf_q[0];

  ptc_samp_s new_samp;
  assign new_samp = '{
    src:   cfg.wave_sel,                                         // [RL4]
    gen:   cfg.gen_sel,                                          // [RL3]
    gated: (cfg.wave_sel == 2'd2) && (lead_units < cfg.trig_dly),
    ofs:   cfg.ch_sum ? cfg.dig_ofs : cfg.dig_ofs                // [RL5]
  };

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cnt   <= 4'h0;
      lead_cnt   <= 4'h0;
      lead_units <= 16'h0000;
    end else begin
      if (!in_play || samp_push) hold_cnt <= 4'h0;
      else if (!hold_done) hold_cnt <= hold_cnt + 4'h1;
      if (!in_play || lead_tick) lead_cnt <= 4'h0;
      else lead_cnt <= lead_cnt + 4'h1;
      if (!in_play) lead_units <= 16'h0000;
      else if (lead_tick && lead_units != 16'hFFFF) lead_units <= lead_units + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_cnt  <= 2'd0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      buf_cnt <= buf_cnt + {1'b0, samp_push} - {1'b0, buf_rd};
      if (buf_rd) buf_q[0] <= (buf_cnt == 2'd2) ? buf_q[1] : new_samp;
      else if (samp_push && buf_cnt == 2'd0) buf_q[0] <= new_samp;
      if (samp_push && (buf_cnt - {1'b0, buf_rd}) == 2'd1) buf_q[1] <= new_samp;
    end
  end

  // ****************************************************************
  // Marker: manual or timed from trigger and pattern end
  // ****************************************************************
  logic        mrk_timed, mrk_rise_run, mrk_fall_run;
  logic [15:0] rise_cnt;
  logic [3:0]  fall_cnt;
  wire         rise_hit = mrk_rise_run && (rise_cnt == cfg.mrk_rise);   // [RL10]
  wire         fall_hit = mrk_fall_run && (fall_cnt == cfg.mrk_fall);   // [RL11]

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mrk_timed    <= 1'b0;
      mrk_rise_run <= 1'b0;
      mrk_fall_run <= 1'b0;
      rise_cnt     <= 16'h0000;
      fall_cnt     <= 4'h0;
    end else begin
      if (trig_fall && run) mrk_rise_run <= 1'b1;
      else if (rise_hit) mrk_rise_run <= 1'b0;
      rise_cnt <= mrk_rise_run ? rise_cnt + 16'h0001 : 16'h0001;
      // A zero fall delay drops at once; a running count would wrap and hit later
      if (pat_end && cfg.mrk_fall != 4'h0) mrk_fall_run <= 1'b1;
      else if (fall_hit) mrk_fall_run <= 1'b0;
      fall_cnt <= mrk_fall_run ? fall_cnt + 4'h1 : 4'h1;
      if (rise_hit) mrk_timed <= 1'b1;
      else if (fall_hit || (pat_end && cfg.mrk_fall == 4'h0)) mrk_timed <= 1'b0;
    end
  end

  // [RL12] [RL13] [RL14]
  assign marker_o    = cfg.mrk_mode ? mrk_timed : cfg.mrk_level;
  assign marker_oe_o = marker_en_i;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  upd_copy_a: assert property (do_upd |-> ##2 (cfg == $past(next_cfg))) // [RL16]
    else $error("update did not load the active set");
  start_delay_a: assert property ($rose(state == PTC_DELAY) && cfg.trig_dly == 16'd3 // [RL2]
    |-> ##4 in_play)
    else $error("pattern start delay wrong");
  manual_mark_a: assert property (!cfg.mrk_mode |-> marker_o == cfg.mrk_level) // [RL13]
    else $error("manual marker level not driven");
  timed_mark_a: assert property (cfg.mrk_mode && rise_hit |=> marker_o) // [RL10] [RL12]
    else $error("timed marker did not rise");
  last_play_a: assert property (pat_end |=> state == PTC_IDLE) // [RL1]
    else $error("pattern did not stop at end");
  run_gate_a: assert property (!run && state == PTC_IDLE |=> state == PTC_IDLE) // [RL15]
    else $error("pattern started without run");
  hold_len_a: assert property (samp_push && cfg.hold == 4'd2 // [RL6]
    |=> !samp_push ##1 !samp_push)
    else $error("sample hold too short");
  buf_safe_a: assert property (buf_cnt != 2'd3)
    else $error("buffer overflow");
  dly_hold_a: assert property (state == PTC_DELAY && !dly_done |=> state == PTC_DELAY) // [RL2]
    else $error("start delay ended early");
  cont_play_a: assert property (period_end && !cfg.rpt_mode && run |=> in_play) // [RL1]
    else $error("continuous pattern stopped");
  fall_mark_a: assert property (cfg.mrk_mode && fall_hit && !rise_hit |=> !marker_o) // [RL11]
    else $error("timed marker did not fall");
  stall_keep_a: assert property (hold_stall // [RL17]
    |=> $stable(unit_cnt) && $stable(base_cnt))
    else $error("period advanced during stall");
  word_keep_a: assert property (samp_valid_o && !samp_ready_i
    |=> samp_valid_o && $stable(samp_o))
    else $error("stalled word changed");
  rd_zero_a: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside the read cycle");

  // Unstalled clocks in the current period, kept only for the length check
  logic [19:0] per_clks;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) per_clks <= 20'h00000;
    else if (!in_play || period_end) per_clks <= 20'h00000;
    else if (!hold_stall) per_clks <= per_clks + 20'h00001;
  end
  per_len_a: assert property (period_end |-> // [RL7] [RL17]
    per_clks == 20'(cfg.period) * (20'(cfg.per_base) + 20'h00001) - 20'h00001)
    else $error("pattern period length wrong");

  play_cv:  cover property ($rose(in_play));
  end_cv:   cover property (pat_end && cfg.rpt_mode);
  stall_cv: cover property (hold_stall);
  stop_cv:  cover property (pat_end && !cfg.rpt_mode);
  fall_cv:  cover property (fall_hit && cfg.mrk_mode);

endmodule : ptc_core

/* File: bench/ptc_sink.sv */
// Far-side model of the DAC sample path: takes words promptly, at random or not at all
`timescale 1ns/1ns
module ptc_sink (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Stream from the block
  input  wire logic       samp_valid_i,
  output logic            samp_ready_o,
  // Behaviour: 0 prompt, 1 random stalls, 2 held off
  input  wire logic [1:0] stall_mode_i
);
  // Ready only moves just after an edge, as a real receiver register would
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      samp_ready_o <= 1'h0;
    end else begin
      case (stall_mode_i)
        2'h0: samp_ready_o <= 1'h1;
        2'h1: samp_ready_o <= 1'($urandom_range(1));
        default: samp_ready_o <= 1'h0;
      endcase
    end
  end
endmodule : ptc_sink

/* File: bench/tb_top.sv */
// Self-checking bench for the pattern timing control block
`timescale 1ns/1ns
module tb_top;
  import ptc_pkg::*;
  logic        sys_clk = 1'h0;
  logic        rst;
  logic        reg_wr;
  logic        reg_rd;
  logic        trig_n;
  logic        mrk_en;
  logic        valid;
  logic        ready;
  logic        marker;
  logic        marker_oe;
  logic        playing;
  logic        strm_on;
  logic        gap_on;
  logic [1:0]  stall_mode;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] exp_word;
  ptc_samp_s   samp;
  int          mismatches;
  int          checks_done;
  int          cycles;
  time         last_t;
  logic [15:0] model [9];
  logic [7:0]  addrs [9] = '{ADDR_RPT_MODE, ADDR_TRIG_DLY, ADDR_DIG_OFS, ADDR_WAV_SRC,
                             ADDR_TBASE, ADDR_PERIOD, ADDR_RPT_CNT, ADDR_MRK_RISE, ADDR_MRK_CFG};
  logic [15:0] rsts [9] = '{16'h0000, 16'h000E, 16'h0000, 16'h0101, 16'h0111, 16'h8000,
                            16'h0101, 16'h0003, 16'h0000};

  always #20 sys_clk = ~sys_clk;

  ptc_core uut (
    .sys_clk_i   (sys_clk),
    .rst_i       (rst),
    .reg_addr_i  (addr),
    .reg_wdata_i (wdata),
    .reg_wr_i    (reg_wr),
    .reg_rd_i    (reg_rd),
    .reg_rdata_o (rdata),
    .trigger_n_i (trig_n),
    .marker_en_i (mrk_en),
    .samp_valid_o(valid),
    .samp_ready_i(ready),
    .samp_o      (samp),
    .marker_o    (marker),
    .marker_oe_o (marker_oe),
    .playing_o   (playing)
  );

  ptc_sink u_sink (
    .sys_clk_i   (sys_clk),
    .rst_i       (rst),
    .samp_valid_i(valid),
    .samp_ready_o(ready),
    .stall_mode_i(stall_mode)
  );

  // ****************************************************************
  // Comparisons, bus cycles and the closing report
  // ****************************************************************
  task automatic wrap_up;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_reg(input logic [7:0] a, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected read at %0t addr %h: got %h expected %h", $time, a, got, exp);
    end
  endtask : chk_reg

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, then fall back to zero
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    addr   <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 chk_reg(a, rdata, exp);
    @(posedge sys_clk);
    #1 chk_reg(a, rdata, 16'h0000);
  endtask : rd_chk

  task automatic setup(input logic [15:0] dly, rise, cfg, cnt, per, tbase, wav);
    wr(ADDR_RPT_MODE, 16'h0001);
    wr(ADDR_TRIG_DLY, dly);
    wr(ADDR_MRK_RISE, rise);
    wr(ADDR_MRK_CFG, cfg);
    wr(ADDR_RPT_CNT, cnt);
    wr(ADDR_PERIOD, per);
    wr(ADDR_TBASE, tbase);
    wr(ADDR_WAV_SRC, wav);
    wr(ADDR_UPDATE, 16'h0001);
    repeat (3) @(posedge sys_clk);
  endtask : setup

  // Pulls the trigger and times playing and marker rise from the falling edge, marker fall from pattern end
  task automatic fire(output int t_play, t_len, t_rise, t_fall);
    int k;
    int t_end;
    t_play = -1;
    t_rise = -1;
    t_end  = -1;
    t_fall = -1;
    t_len  = 0;
    @(posedge sys_clk);
    trig_n <= 1'h0;
    for (k = 1; k < 600 && t_fall < 0; k++) begin
      @(posedge sys_clk);
      if (k == 4) trig_n <= 1'h1;
      #1;
      if (playing === 1'h1 && t_play < 0) t_play = k;
      if (playing === 1'h1) t_len++;
      if (marker === 1'h1 && t_rise < 0) t_rise = k;
      if (t_play >= 0 && playing === 1'h0 && t_end < 0) t_end = k;
      if (t_end >= 0 && marker === 1'h0 && t_fall < 0) t_fall = k - t_end;
    end
  endtask : fire

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  // Every word handed over carries the active source, generator and offset
  always @(posedge sys_clk) begin
    if (valid === 1'h1 && ready === 1'h1) begin
      if (strm_on) chk_val({samp.src, samp.gen, samp.ofs}, exp_word);
      if (gap_on && last_t > 0) chk_val(32'(($time - last_t) / 40), 3);
      last_t = $time;
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int i;
    int pa, la, ra, fa, pb, lb, rb, fb;
    logic [31:0] w;
    {rst, trig_n} = 2'h3;
    {reg_wr, reg_rd, mrk_en, strm_on, gap_on} = 5'h00;
    {stall_mode, addr, wdata, exp_word} = 42'h0;
    {mismatches, checks_done, cycles} = {32'h0, 32'h0, 32'h0};
    last_t = 0;
    w = $urandom(33274);
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    for (i = 0; i < 9; i++) rd_chk(addrs[i], rsts[i]);
    wr(8'h30, 16'hFFFF);
    rd_chk(8'h30, 16'h0000);
    wr(ADDR_UPDATE, 16'h0001);
    rd_chk(ADDR_UPDATE, 16'h0000);
    for (i = 0; i < 9; i++) begin
      model[i] = 16'($urandom);
      wr(addrs[i], model[i]);
    end
    for (i = 0; i < 9; i++) rd_chk(addrs[i], model[i]);
    // Manual marker: a written level waits for the update strobe
    mrk_en <= 1'h1;
    wr(ADDR_MRK_CFG, 16'h0000);
    wr(ADDR_UPDATE, 16'h0001);
    wr(ADDR_MRK_CFG, 16'h0020);
    repeat (3) @(posedge sys_clk);
    #1 chk_val(marker, 0);
    wr(ADDR_UPDATE, 16'h0001);
    repeat (3) @(posedge sys_clk);
    #1 chk_val(marker, 1);
    chk_val(marker_oe, 1);
    wr(ADDR_STATUS, 16'h0001);
    rd_chk(ADDR_STATUS, 16'h0001);
    // Timed marker with the manual level still set: two runs compared edge by edge
    gap_on = 1'h1;
    setup(16'h0003, 16'h0004, 16'h0030, 16'h0000, 16'h0004, 16'h0220, 16'h0001);
    fire(pa, la, ra, fa);
    gap_on = 1'h0;
    chk_val(la, 12);
    chk_val(ra, 3 + 4);
    w = $urandom;
    wr(ADDR_DIG_OFS, w[31:16]);
    exp_word = {w[1:0], w[5:4], w[31:20]};
    setup(16'h000B, 16'h0009, 16'h0035, 16'h0002, 16'h0003, 16'h0000,
          {10'h000, w[5:4], 2'h0, w[1:0]});
    strm_on = 1'h1;
    fire(pb, lb, rb, fb);
    chk_val(pb - pa, 8);
    chk_val(rb - ra, 5);
    chk_val(fb - fa, 5);
    chk_val(lb, 9);
    // Continuous run with a stalled receiver, then the run bit is cleared
    wr(ADDR_RPT_MODE, 16'h0000);
    wr(ADDR_UPDATE, 16'h0001);
    stall_mode <= 2'h2;
    trig_n <= 1'h0;
    repeat (5) @(posedge sys_clk);
    trig_n <= 1'h1;
    repeat (60) @(posedge sys_clk);
    #1 chk_val(valid, 1);
    stall_mode <= 2'h1;
    repeat (100) @(posedge sys_clk);
    rd_chk(ADDR_STATUS, 16'h0003);
    wr(ADDR_STATUS, 16'h0000);
    for (i = 0; i < 200 && playing !== 1'h0; i++) @(posedge sys_clk);
    #1 chk_val(playing, 0);
    stall_mode <= 2'h0;
    repeat (10) @(posedge sys_clk);
    #1 chk_val(valid, 0);
    strm_on = 1'h0;
    wrap_up();
  end
endmodule : tb_top
